// >>> rcf_reset_cause_flags.sv
/*
 Reset-cause status register with clear, set and invert aliases.
 Assumes event inputs from the reset-source logic are asynchronous levels or
 pulses of at least two ref_clk periods; the register port is on ref_clk.
*/
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module rcf_reset_cause_flags (
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire logic [rcf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  input  wire logic                       supply_por_evt,
  input  wire logic                       core_por_evt,
  input  wire logic                       cfg_primary_err_evt,
  input  wire logic                       cfg_alternate_err_evt,
  input  wire logic                       cfg_mismatch_evt,
  input  wire logic                       master_clear_pin,
  input  wire logic                       sw_reset_evt,
  input  wire logic                       wdt_expire_evt,
  input  wire logic                       brownout_evt,
  input  wire logic                       sleep_wake_evt,
  input  wire logic                       idle_wake_evt,
  output logic      [31:0]                reset_cause_status
);
  import rcf_pkg::*;

  // ---------------------------------------------------------------------------
  // Event synchronisation and edge detection
  // ---------------------------------------------------------------------------
  localparam int NEV = 11;

  logic [NEV-1:0] ev_raw;
  logic [NEV-1:0] ev_sync;
  logic [NEV-1:0] ev_last_q;
  logic [NEV-1:0] ev_rise;

  assign ev_raw = {supply_por_evt, core_por_evt, cfg_primary_err_evt,
                   cfg_alternate_err_evt, cfg_mismatch_evt, master_clear_pin,
                   sw_reset_evt, wdt_expire_evt, brownout_evt,
                   sleep_wake_evt, idle_wake_evt};

  rcf_sync #(
    .W (NEV)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in (ev_raw),
    .sync_out (ev_sync)
  );

  // Levels held high set the flag once; a clear is not undone until the
  // source drops and rises again, so software sees the next detection only.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      ev_last_q <= '0;
    else
      ev_last_q <= ev_sync;
  end

  assign ev_rise = ev_sync & ~ev_last_q;

  logic e_sup;
  logic e_core;
  logic e_perr;
  logic e_aerr;
  logic e_mism;
  logic e_pin;
  logic e_soft;
  logic e_wdt;
  logic e_brown;
  logic e_sleep;
  logic e_idle;

  assign {e_sup, e_core, e_perr, e_aerr, e_mism, e_pin,
          e_soft, e_wdt, e_brown, e_sleep, e_idle} = ev_rise;

  // The alternate error only matters when the primary read failed too.
  logic cfg_err_seen_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      cfg_err_seen_q <= 1'b0;
    else if (e_perr)
      cfg_err_seen_q <= 1'b1;
    else if (e_aerr)
      cfg_err_seen_q <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Hardware set vector
  // ---------------------------------------------------------------------------
  logic [31:0] hw_set;

  always_comb
  begin
    hw_set = ZERO_WORD;
    hw_set[BIT_SUPPLY_POR] = e_sup;
    hw_set[BIT_CORE_POR] = e_core;
    hw_set[BIT_CFG_ERR] = e_perr;
    hw_set[BIT_CFG_FAIL] = e_aerr & (cfg_err_seen_q | e_perr);
    hw_set[BIT_CFG_MISM] = e_mism;
    hw_set[BIT_EXT_PIN] = e_pin;
    hw_set[BIT_SW_RESET] = e_soft;
    hw_set[BIT_WDT_TIMEOUT] = e_wdt;
    hw_set[BIT_SLEEP_WAKE] = e_sleep;
    hw_set[BIT_IDLE_WAKE] = e_idle | e_sleep;
    hw_set[BIT_BROWNOUT] = e_brown;
    hw_set[BIT_ANY_POR] = e_sup | e_core;
  end

  // ---------------------------------------------------------------------------
  // Register write decode
  // ---------------------------------------------------------------------------
  // True for the register itself and its three atomic views.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      RCS_BASE, RCS_CLR_OFS, RCS_SET_OFS, RCS_INV_OFS:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction : addr_hit

  function automatic logic [31:0] sw_next(input logic [ADDR_W-1:0] a,
                                          input logic [31:0]       cur,
                                          input logic [31:0]       wd);
    logic [31:0] r;
    r = cur;
    case (a)
      RCS_BASE:    r = wd;
      RCS_CLR_OFS: r = cur & ~wd;
      RCS_SET_OFS: r = cur | wd;
      RCS_INV_OFS: r = cur ^ wd;
      default:     r = cur;
    endcase
    return r;
  endfunction : sw_next

  // set wins over clear
  // A cause landing while software tidies up is never lost to the clear.
  function automatic logic flag_next(input logic sw_bit,
                                     input logic hw_bit);
    return sw_bit | hw_bit;
  endfunction : flag_next

  logic        supply_flag_q;
  logic        core_flag_q;
  logic        cfg_error_flag_q;
  logic        cfg_fail_flag_q;
  logic        mismatch_flag_q;
  logic        pin_flag_q;
  logic        soft_flag_q;
  logic        wdt_flag_q;
  logic        sleep_flag_q;
  logic        idle_flag_q;
  logic        brown_flag_q;
  logic        any_por_flag_q;
  logic [31:0] status_now;
  logic [31:0] sw_val;

  always_comb
  begin
    sw_val = status_now;
    if (reg_wr && addr_hit(reg_addr))
      sw_val = sw_next(reg_addr, status_now, reg_wdata) & RCS_IMPL_MASK;
  end

  // ---------------------------------------------------------------------------
  // Flag registers
  // ---------------------------------------------------------------------------
  // supply power-on flag
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      supply_flag_q <= RCS_RESET_VAL[BIT_SUPPLY_POR];
    else
      supply_flag_q <= flag_next(sw_val[BIT_SUPPLY_POR], hw_set[BIT_SUPPLY_POR]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      core_flag_q <= RCS_RESET_VAL[BIT_CORE_POR];
    else
      core_flag_q <= flag_next(sw_val[BIT_CORE_POR], hw_set[BIT_CORE_POR]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      cfg_error_flag_q <= RCS_RESET_VAL[BIT_CFG_ERR];
    else
      cfg_error_flag_q <= flag_next(sw_val[BIT_CFG_ERR], hw_set[BIT_CFG_ERR]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      cfg_fail_flag_q <= RCS_RESET_VAL[BIT_CFG_FAIL];
    else
      cfg_fail_flag_q <= flag_next(sw_val[BIT_CFG_FAIL], hw_set[BIT_CFG_FAIL]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      mismatch_flag_q <= RCS_RESET_VAL[BIT_CFG_MISM];
    else
      mismatch_flag_q <= flag_next(sw_val[BIT_CFG_MISM], hw_set[BIT_CFG_MISM]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      pin_flag_q <= RCS_RESET_VAL[BIT_EXT_PIN];
    else
      pin_flag_q <= flag_next(sw_val[BIT_EXT_PIN], hw_set[BIT_EXT_PIN]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      soft_flag_q <= RCS_RESET_VAL[BIT_SW_RESET];
    else
      soft_flag_q <= flag_next(sw_val[BIT_SW_RESET], hw_set[BIT_SW_RESET]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      wdt_flag_q <= RCS_RESET_VAL[BIT_WDT_TIMEOUT];
    else
      wdt_flag_q <= flag_next(sw_val[BIT_WDT_TIMEOUT], hw_set[BIT_WDT_TIMEOUT]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      sleep_flag_q <= RCS_RESET_VAL[BIT_SLEEP_WAKE];
    else
      sleep_flag_q <= flag_next(sw_val[BIT_SLEEP_WAKE], hw_set[BIT_SLEEP_WAKE]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      idle_flag_q <= RCS_RESET_VAL[BIT_IDLE_WAKE];
    else
      idle_flag_q <= flag_next(sw_val[BIT_IDLE_WAKE], hw_set[BIT_IDLE_WAKE]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      brown_flag_q <= RCS_RESET_VAL[BIT_BROWNOUT];
    else
      brown_flag_q <= flag_next(sw_val[BIT_BROWNOUT], hw_set[BIT_BROWNOUT]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      any_por_flag_q <= RCS_RESET_VAL[BIT_ANY_POR];
    else
      any_por_flag_q <= flag_next(sw_val[BIT_ANY_POR], hw_set[BIT_ANY_POR]);
  end

  // ---------------------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------------------
  // unimplemented bits zero
  always_comb
  begin
    status_now                  = ZERO_WORD;
    status_now[BIT_SUPPLY_POR]  = supply_flag_q;
    status_now[BIT_CORE_POR]    = core_flag_q;
    status_now[BIT_CFG_ERR]     = cfg_error_flag_q;
    status_now[BIT_CFG_FAIL]    = cfg_fail_flag_q;
    status_now[BIT_CFG_MISM]    = mismatch_flag_q;
    status_now[BIT_EXT_PIN]     = pin_flag_q;
    status_now[BIT_SW_RESET]    = soft_flag_q;
    status_now[BIT_WDT_TIMEOUT] = wdt_flag_q;
    status_now[BIT_SLEEP_WAKE]  = sleep_flag_q;
    status_now[BIT_IDLE_WAKE]   = idle_flag_q;
    status_now[BIT_BROWNOUT]    = brown_flag_q;
    status_now[BIT_ANY_POR]     = any_por_flag_q;
  end

  assign reset_cause_status = status_now;

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  // Aliases read back the register itself so software can inspect any view.
  // unimplemented bits zero
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      reg_rdata <= ZERO_WORD;
    else if (reg_rd && addr_hit(reg_addr))
      reg_rdata <= status_now & RCS_IMPL_MASK;
    else
      reg_rdata <= ZERO_WORD;
  end
endmodule : rcf_reset_cause_flags

// >>> rcf_pkg.sv
/*
 Package for the reset-cause flag register: offsets, bit positions, reset values.
 Assumes a 32-bit word-addressed register port with byte addresses.
*/
package rcf_pkg;
  // ---------------------------------------------------------------------------
  // Addresses
  // ---------------------------------------------------------------------------
  localparam int                ADDR_W          = 8;
  localparam logic [ADDR_W-1:0] RCS_BASE        = 8'h00;
  localparam logic [ADDR_W-1:0] RCS_CLR_OFS     = 8'h04;
  localparam logic [ADDR_W-1:0] RCS_SET_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] RCS_INV_OFS     = 8'h0C;
  // ---------------------------------------------------------------------------
  // Bit positions
  // ---------------------------------------------------------------------------
  localparam int BIT_SUPPLY_POR  = 31;
  localparam int BIT_CORE_POR    = 30;
  localparam int BIT_CFG_ERR     = 27;
  localparam int BIT_CFG_FAIL    = 26;
  localparam int BIT_CFG_MISM    = 9;
  localparam int BIT_EXT_PIN     = 7;
  localparam int BIT_SW_RESET    = 6;
  localparam int BIT_WDT_TIMEOUT = 4;
  localparam int BIT_SLEEP_WAKE  = 3;
  localparam int BIT_IDLE_WAKE   = 2;
  localparam int BIT_BROWNOUT    = 1;
  localparam int BIT_ANY_POR     = 0;
  // Implemented bits and value after power-on.
  localparam logic [31:0] RCS_IMPL_MASK = 32'hCC0002DF;
  localparam logic [31:0] RCS_RESET_VAL = 32'hC0000003;
  localparam logic [31:0] ZERO_WORD     = 32'h00000000;
endpackage : rcf_pkg

// >>> rcf_sync.sv
/*
 Two-flop synchroniser for a vector of asynchronous event levels.
 Assumes the inputs are held for at least two clock periods.
*/
`timescale 1ns/100ps
module rcf_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : rcf_sync

// >>> rcf_assertions.sv
/*
 Checker for the reset-cause flag register, bound to its top module.
 Assumes event inputs stay high for at least two clocks.
*/
`timescale 1ns/100ps
module rcf_chk (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        supply_por_evt,
  input wire logic        core_por_evt,
  input wire logic        cfg_primary_err_evt,
  input wire logic        master_clear_pin,
  input wire logic        wdt_expire_evt,
  input wire logic        brownout_evt,
  input wire logic        sleep_wake_evt,
  input wire logic [31:0] reset_cause_status
);
  import rcf_pkg::*;
  logic [31:0] st;
  assign st = reset_cause_status;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------------------------
  // Flag setting and holding
  // ---------------------------------------------------------------------------
  supply_set_a: assert property ($rose(supply_por_evt) |-> ##[1:6] (st[31] && st[0]))
    else $error("supply flag late");
  core_set_a: assert property ($rose(core_por_evt) |-> ##[1:6] (st[30] && st[0]))
    else $error("core flag late");
  cfg_err_a: assert property ($rose(cfg_primary_err_evt) |-> ##[1:6] st[27])
    else $error("config error flag late");
  pin_reset_a: assert property ($rose(master_clear_pin) |-> ##[1:6] st[7])
    else $error("pin flag late");
  wdt_set_a: assert property ($rose(wdt_expire_evt) |-> ##[1:6] st[4])
    else $error("watchdog flag late");
  brownout_set_a: assert property ($rose(brownout_evt) |-> ##[1:6] st[1])
    else $error("brownout flag late");
  sleep_wake_a: assert property ($rose(sleep_wake_evt) |-> ##[1:6] (st[3] && st[2]))
    else $error("wake flags late");
  sticky_flags_a: assert property (!$past(reg_wr) |-> ($past(st) & ~st) == 32'h0)
    else $error("flag dropped without write");
  unimpl_zero_a: assert property ((st & ~RCS_IMPL_MASK) == 32'h0)
    else $error("unimplemented bit set");
  set_alias_a: assert property (reg_wr && reg_addr == RCS_SET_OFS |=>
    (st & $past(reg_wdata) & RCS_IMPL_MASK) == ($past(reg_wdata) & RCS_IMPL_MASK)) else $error("set alias");
  cover property (reg_wr && reg_addr == RCS_CLR_OFS);
  cover property (reg_rd && reg_addr == 8'h10);
  cover property ($rose(sleep_wake_evt));
endmodule : rcf_chk
bind rcf_reset_cause_flags rcf_chk chk_u (.*);

// >>> tb_top.sv
/*
 Self-checking bench with a behavioural flag model.
 Assumes read data stand one cycle after the read strobe.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("mismatch %0t got %h want %h", $time, a, b); end end
module tb_top;
  import rcf_pkg::*;
  logic        ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, reset_cause_status, mdl, r, seed = 32'h8583;
  logic [10:0] ev = 0;
  int          fails = 0, total_checks = 0;
  int          ev_i [13] = '{3, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 3};
  logic [31:0] ev_m [13] = '{32'h0, 32'h80000001, 32'h40000001, 32'h08000000, 32'h04000000, 32'h200,
                             32'h80, 32'h40, 32'h10, 32'h2, 32'hC, 32'h4, 32'h0};
  rcf_reset_cause_flags dut_u (.*, .supply_por_evt(ev[0]), .core_por_evt(ev[1]), .cfg_primary_err_evt(ev[2]),
    .cfg_alternate_err_evt(ev[3]), .cfg_mismatch_evt(ev[4]), .master_clear_pin(ev[5]), .sw_reset_evt(ev[6]),
    .wdt_expire_evt(ev[7]), .brownout_evt(ev[8]), .sleep_wake_evt(ev[9]), .idle_wake_evt(ev[10]));
  always #50 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    case (a)
      RCS_BASE: mdl = d & RCS_IMPL_MASK;
      RCS_CLR_OFS: mdl &= ~d;
      RCS_SET_OFS: mdl |= d & RCS_IMPL_MASK;
      RCS_INV_OFS: mdl ^= d & RCS_IMPL_MASK;
      default: ;
    endcase
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(reg_rdata, (a < 8'h10) ? mdl : ZERO_WORD)
    `CHK(reset_cause_status, mdl)
    @(posedge ref_clk);
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  initial
  begin
    #500000;
    fails++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    mdl = RCS_RESET_VAL;
    @(posedge ref_clk);
    rd(RCS_BASE);
    wr(RCS_CLR_OFS, 32'hFFFFFFFF);
    foreach (ev_i[k])
    begin
      ev[ev_i[k]] <= 1'b1;
      repeat (2 + xs() % 3) @(posedge ref_clk);
      ev[ev_i[k]] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      mdl |= ev_m[k];
      rd(RCS_BASE); // event flags
    end
    // Held level must not set the flag again after a clear.
    ev[8] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wr(RCS_CLR_OFS, 32'h2);
    repeat (4) @(posedge ref_clk);
    rd(RCS_BASE); // held level
    ev[8] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    // The clear is sampled in the very cycle the pin event lands; the set must win.
    ev[5] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    wr(RCS_CLR_OFS, 32'h00000080);
    ev[5] <= 1'b0;
    mdl |= 32'h00000080;
    rd(RCS_BASE); // set beats clear
    repeat (40)
    begin
      r = xs();
      wr({3'b000, r[4], r[3:2], 2'b00}, xs());
      rd({3'b000, r[9], r[8:7], 2'b00}); // alias access
    end
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    mdl = RCS_RESET_VAL;
    @(posedge ref_clk);
    rd(RCS_BASE); // reset value
    close_out();
  end
endmodule : tb_top
